// >>> logic/clk_ctrl_consts.svh
// Register offsets, reset values and field positions of the clock control block.
`ifndef CLK_CTRL_CONSTS_SVH
`define CLK_CTRL_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PCE_ONE_OFS 12'h030
`define PCE_TWO_OFS 12'h034
`define CSC_OFS 12'h040
`define SCS_OFS 12'h044
`define FWAIT_OFS 12'h0B0
`define CSTAT_OFS 12'h0B4

// ****************************************
// Reset values and writable masks
// ****************************************
`define PCE_ONE_RST 32'h0000000F
`define PCE_TWO_RST 32'h00000101
`define CSC_RST 32'h00000020
`define SCS_RST 32'h00000000
`define FWAIT_RST 32'h00000000
`define PCE_MASK 32'hFFFFFFFF
`define CSC_MASK 32'h00000033
`define SCS_MASK 32'h00000003
`define FWAIT_MASK 32'h00000003

// ****************************************
// Field positions
// ****************************************
`define CSC_MAIN_XTAL_BIT 0
`define CSC_SUB_XTAL_BIT 1
`define CSC_FAST_BIT 4
`define CSC_SLOW_BIT 5
`define SCS_SEL_MSB 1
`define FWAIT_MSB 1
`define CSTAT_BUSY_BIT 2

// ****************************************
// Bus response codes
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> logic/clk_ctrl_pkg.sv
// Types shared by the clock control modules.
package clk_ctrl_pkg;

   typedef enum logic [1:0] {
      SRC_SLOW = 2'b00,
      SRC_SUB = 2'b01,
      SRC_FAST = 2'b10,
      SRC_MAIN = 2'b11
   } clk_src_t;

   typedef enum logic [1:0] {
      MODE_RUN = 2'b00,
      MODE_SLEEP = 2'b01,
      MODE_PD = 2'b10,
      MODE_INIT = 2'b11
   } op_mode_t;

   typedef enum logic [1:0] {
      MUX_FOLLOW = 2'b00,
      MUX_WAIT_HIGH = 2'b01,
      MUX_WAIT_LOW = 2'b10
   } mux_state_t;

   typedef enum logic [2:0] {
      RID_NONE = 3'b000,
      RID_PCE1 = 3'b001,
      RID_PCE2 = 3'b010,
      RID_CSC = 3'b011,
      RID_SCS = 3'b100,
      RID_FWAIT = 3'b101,
      RID_STAT = 3'b110
   } reg_id_t;

endpackage : clk_ctrl_pkg

// >>> logic/clock_gate.sv
// Glitch-free clock gate on a sampled clock level.
`timescale 1ns/1ps

module clock_gate
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Source level and enable
   input wire logic src_lvl_in,
   input wire logic en_in,
   // Gated level
   output logic gclk_out
);
   import clk_ctrl_pkg::*;

   typedef struct packed {
      logic en;
      logic out;
   } gate_reg_t;

   gate_reg_t r_r;
   gate_reg_t r_nxt;

   // The enable is only taken while the source is low, so a pulse is never cut short.
   always_comb
   begin
      r_nxt = r_r;
      r_nxt.en = src_lvl_in ? r_r.en : en_in;
      r_nxt.out = src_lvl_in & r_nxt.en;
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   assign gclk_out = r_r.out;

endmodule : clock_gate

// >>> logic/glitch_free_mux.sv
// Glitch-free selector between sampled oscillator levels.
`timescale 1ns/1ps

module glitch_free_mux
#(
   parameter int NSRC = 4
)
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Sources and selection
   input wire logic [NSRC-1:0] src_lvl_in,
   input wire logic [$clog2(NSRC)-1:0] sel_in,
   // Selected level and status
   output logic clk_lvl_out,
   output logic [$clog2(NSRC)-1:0] cur_sel_out,
   output logic busy_out
);
   import clk_ctrl_pkg::*;

   localparam int SW = $clog2(NSRC);

   generate
      if (NSRC < 2)
      begin : g_bad_nsrc
         $error("glitch_free_mux needs at least two sources");
      end
   endgenerate

   typedef struct packed {
      mux_state_t st;
      logic [SW-1:0] cur;
      logic [SW-1:0] nsel;
      logic out;
   } mux_reg_t;

   mux_reg_t r_r;
   mux_reg_t r_nxt;

   // ****************************************
   // Switch sequence
   // ****************************************
   // The old source is left only in its low phase and the new one is joined only
   // at the fall that ends one of its high phases, so the output never carries a runt pulse. A dead
   // new source leaves the switch waiting; an old source stopped low does not.
   always_comb
   begin
      r_nxt = r_r;
      unique case (r_r.st)
         MUX_FOLLOW:
         begin
            r_nxt.out = src_lvl_in[r_r.cur];
            if (sel_in != r_r.cur && !src_lvl_in[r_r.cur])
            begin
               r_nxt.nsel = sel_in;
               r_nxt.out = 1'b0;
               r_nxt.st = MUX_WAIT_HIGH;
            end
         end
         MUX_WAIT_HIGH:
         begin
            r_nxt.out = 1'b0;
            if (src_lvl_in[r_r.nsel])
               r_nxt.st = MUX_WAIT_LOW;
         end
         MUX_WAIT_LOW:
         begin
            r_nxt.out = 1'b0;
            if (!src_lvl_in[r_r.nsel])
            begin
               r_nxt.cur = r_r.nsel;
               r_nxt.st = MUX_FOLLOW;
            end
         end
         default:
         begin
            r_nxt.out = 1'b0;
            r_nxt.st = MUX_FOLLOW;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         r_r <= '{st: MUX_FOLLOW, default: '0};
      else
         r_r <= r_nxt;
   end

   assign clk_lvl_out = r_r.out;
   assign cur_sel_out = r_r.cur;
   assign busy_out = (r_r.st != MUX_FOLLOW);

   // ****************************************
   // Checks
   // ****************************************
   no_runt_rise_a: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(clk_lvl_out) |-> ($past(r_r.st) == MUX_FOLLOW) && $past(src_lvl_in[r_r.cur]))
      else $error("Selected clock rose outside the follow state.");

   dead_source_stall_a: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      (r_r.st == MUX_WAIT_HIGH && !src_lvl_in[r_r.nsel]) |=> (r_r.st == MUX_WAIT_HIGH) && !clk_lvl_out)
      else $error("Switch went on without seeing the new source run.");

   switch_done_c: cover property (
      @(posedge clk_in) disable iff (!resetn_in)
      (r_r.st == MUX_WAIT_LOW) ##1 (r_r.st == MUX_FOLLOW));

endmodule : glitch_free_mux

// >>> logic/system_clock_control.sv
// Clock source control, main clock selection, clock gating and flash wait setting.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "clk_ctrl_consts.svh"

// What this block does
// - After reset the main clock runs from the enabled slow internal oscillator.
// - Software may enable any other oscillator while running from the slow one.
// - Every source selector switches without glitches or runt pulses.
// - Switch only between running sources; a stopped new source makes the switch wait forever.
// - Provide a CPU/bus clock and a peripheral master clock.
// - The free-running core clock stops only in power-down mode.
// - The CPU/bus clock stops in sleep and power-down modes.
// - Bus fabric and memories run from the selected main clock.
// - Each peripheral clock is gated by its own enable bit.
// - A peripheral with its clock disabled refuses all register access.
// - The checksum unit gets an auxiliary clock that stops in power-down.
// - The clock source control register enables the fast internal oscillator.
// - The main clock source follows the system clock select register.
// - Flash wait field: 00 zero, 01 one, 11 two waits; set first.
module system_clock_control
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Register bus write channels
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // Register bus read channels
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Oscillator levels
   input wire logic slow_internal_osc_in,
   input wire logic sub_crystal_osc_in,
   input wire logic fast_internal_osc_in,
   input wire logic main_crystal_osc_in,
   // Operating mode from the power logic
   input wire clk_ctrl_pkg::op_mode_t mode_in,
   // Oscillator enables
   output logic slow_internal_osc_en_out,
   output logic sub_crystal_osc_en_out,
   output logic fast_internal_osc_en_out,
   output logic main_crystal_osc_en_out,
   // Generated clocks
   output logic main_clock_out,
   output logic free_running_core_clock_out,
   output logic cpu_bus_clock_out,
   output logic periph_master_clock_out,
   output logic checksum_unit_clock_out,
   output logic [63:0] periph_clock_out,
   // Peripheral access and flash timing
   output logic [63:0] periph_access_en_out,
   output logic [1:0] flash_wait_states_out
);
   import clk_ctrl_pkg::*;

   typedef struct packed {
      logic [3:0] osc_s1;
      logic [3:0] osc_s2;
      logic [31:0] pce_one;
      logic [31:0] pce_two;
      logic [31:0] csc;
      logic [31:0] scs;
      logic [31:0] fwait;
      logic aw_got;
      logic [11:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic b_valid;
      logic [1:0] b_resp;
      logic r_valid;
      logic [31:0] r_data;
      logic [1:0] r_resp;
   } ctl_reg_t;

   localparam ctl_reg_t CTL_RST = '{pce_one: `PCE_ONE_RST, pce_two: `PCE_TWO_RST, csc: `CSC_RST, scs: `SCS_RST,
                                    fwait: `FWAIT_RST, default: '0};

   ctl_reg_t r_r;
   ctl_reg_t r_nxt;

   logic [3:0] src_lvl_w;
   logic main_lvl_w;
   logic pm_lvl_w;
   logic [3:0] mode_en_w;
   logic [3:0] mode_clk_w;
   logic [1:0] mux_cur_w;
   logic mux_busy_w;
   logic aw_rdy_w;
   logic w_rdy_w;
   logic ar_rdy_w;
   logic wr_commit_w;
   reg_id_t wr_id_w;

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic reg_id_t reg_id(input logic [11:0] addr);
      reg_id_t id;
      id = RID_NONE;
      unique case ({addr[11:2], 2'b00})
         `PCE_ONE_OFS: id = RID_PCE1;
         `PCE_TWO_OFS: id = RID_PCE2;
         `CSC_OFS: id = RID_CSC;
         `SCS_OFS: id = RID_SCS;
         `FWAIT_OFS: id = RID_FWAIT;
         `CSTAT_OFS: id = RID_STAT;
         default: id = RID_NONE;
      endcase
      return id;
   endfunction : reg_id

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] bm;
      bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return ((old_v & ~bm) | (new_v & bm)) & mask;
   endfunction : merge

   // ****************************************
   // Register bus and register file
   // ****************************************
   assign aw_rdy_w = !r_r.aw_got && !r_r.b_valid;
   assign w_rdy_w = !r_r.w_got && !r_r.b_valid;
   assign ar_rdy_w = !r_r.r_valid;
   assign wr_commit_w = r_r.aw_got && r_r.w_got && !r_r.b_valid;
   assign wr_id_w = reg_id(r_r.aw_addr);

   always_comb
   begin
      r_nxt = r_r;
      r_nxt.osc_s1 = {main_crystal_osc_in, fast_internal_osc_in, sub_crystal_osc_in, slow_internal_osc_in};
      r_nxt.osc_s2 = r_r.osc_s1;
      if (s_axi_awvalid_in && aw_rdy_w)
      begin
         r_nxt.aw_got = 1'b1;
         r_nxt.aw_addr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && w_rdy_w)
      begin
         r_nxt.w_got = 1'b1;
         r_nxt.w_data = s_axi_wdata_in;
         r_nxt.w_strb = s_axi_wstrb_in;
      end
      if (wr_commit_w)
      begin
         r_nxt.aw_got = 1'b0;
         r_nxt.w_got = 1'b0;
         r_nxt.b_valid = 1'b1;
         r_nxt.b_resp = `RESP_OKAY;
         unique case (wr_id_w)
            RID_PCE1: r_nxt.pce_one = merge(r_r.pce_one, r_r.w_data, r_r.w_strb, `PCE_MASK);
            RID_PCE2: r_nxt.pce_two = merge(r_r.pce_two, r_r.w_data, r_r.w_strb, `PCE_MASK);
            RID_CSC: r_nxt.csc = merge(r_r.csc, r_r.w_data, r_r.w_strb, `CSC_MASK);
            RID_SCS: r_nxt.scs = merge(r_r.scs, r_r.w_data, r_r.w_strb, `SCS_MASK);
            RID_FWAIT: r_nxt.fwait = merge(r_r.fwait, r_r.w_data, r_r.w_strb, `FWAIT_MASK);
            RID_STAT: r_nxt.b_resp = `RESP_OKAY;
            RID_NONE: r_nxt.b_resp = `RESP_SLVERR;
         endcase
      end
      else if (r_r.b_valid && s_axi_bready_in)
         r_nxt.b_valid = 1'b0;
      if (s_axi_arvalid_in && ar_rdy_w)
      begin
         r_nxt.r_valid = 1'b1;
         r_nxt.r_resp = `RESP_OKAY;
         unique case (reg_id(s_axi_araddr_in))
            RID_PCE1: r_nxt.r_data = r_r.pce_one;
            RID_PCE2: r_nxt.r_data = r_r.pce_two;
            RID_CSC: r_nxt.r_data = r_r.csc;
            RID_SCS: r_nxt.r_data = r_r.scs;
            RID_FWAIT: r_nxt.r_data = r_r.fwait;
            RID_STAT: r_nxt.r_data = {29'h0, mux_busy_w, mux_cur_w};
            RID_NONE:
            begin
               r_nxt.r_data = 32'h0;
               r_nxt.r_resp = `RESP_SLVERR;
            end
         endcase
      end
      else if (r_r.r_valid && s_axi_rready_in)
         r_nxt.r_valid = 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      if (!resetn_in)
         r_r <= CTL_RST;
      else
         r_r <= r_nxt;
   end

   assign s_axi_awready_out = aw_rdy_w;
   assign s_axi_wready_out = w_rdy_w;
   assign s_axi_bvalid_out = r_r.b_valid;
   assign s_axi_bresp_out = r_r.b_resp;
   assign s_axi_arready_out = ar_rdy_w;
   assign s_axi_rvalid_out = r_r.r_valid;
   assign s_axi_rdata_out = r_r.r_data;
   assign s_axi_rresp_out = r_r.r_resp;

   // ****************************************
   // Oscillator enables and source selection
   // ****************************************
   assign slow_internal_osc_en_out = r_r.csc[`CSC_SLOW_BIT];
   assign sub_crystal_osc_en_out = r_r.csc[`CSC_SUB_XTAL_BIT];
   assign fast_internal_osc_en_out = r_r.csc[`CSC_FAST_BIT];
   assign main_crystal_osc_en_out = r_r.csc[`CSC_MAIN_XTAL_BIT];

   // A disabled oscillator is seen as stopped, whatever its pin does.
   assign src_lvl_w = r_r.osc_s2 & {r_r.csc[`CSC_MAIN_XTAL_BIT], r_r.csc[`CSC_FAST_BIT],
                                    r_r.csc[`CSC_SUB_XTAL_BIT], r_r.csc[`CSC_SLOW_BIT]};

   glitch_free_mux #(.NSRC(4)) u_main_mux (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .src_lvl_in(src_lvl_w),
      .sel_in(r_r.scs[`SCS_SEL_MSB:0]),
      .clk_lvl_out(main_lvl_w),
      .cur_sel_out(mux_cur_w),
      .busy_out(mux_busy_w)
   );

   assign main_clock_out = main_lvl_w;

   // ****************************************
   // Clock gating
   // ****************************************
   // Mode gates from bit 0 up: core clock, CPU/bus clock, peripheral master clock, checksum unit clock.
   assign mode_en_w = {mode_in != MODE_PD, mode_in != MODE_PD, (mode_in == MODE_RUN || mode_in == MODE_INIT),
                       mode_in != MODE_PD};
   generate
      for (genvar gk = 0; gk < 4; gk++)
      begin : g_mode_gate
         clock_gate u_mgate (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .src_lvl_in(main_lvl_w),
            .en_in(mode_en_w[gk]),
            .gclk_out(mode_clk_w[gk])
         );
      end
   endgenerate
   assign {checksum_unit_clock_out, pm_lvl_w, cpu_bus_clock_out, free_running_core_clock_out} = mode_clk_w;
   assign periph_master_clock_out = pm_lvl_w;

   genvar gi;
   generate
      for (gi = 0; gi < 64; gi++)
      begin : g_periph
         clock_gate u_pgate (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .src_lvl_in(pm_lvl_w),
            .en_in(gi < 32 ? r_r.pce_one[gi % 32] : r_r.pce_two[gi % 32]),
            .gclk_out(periph_clock_out[gi])
         );
      end
   endgenerate

   // Register access to a peripheral is allowed only while its clock is enabled.
   assign periph_access_en_out = {r_r.pce_two, r_r.pce_one};
   assign flash_wait_states_out = r_r.fwait[`FWAIT_MSB:0];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   boot_slow_source_a: assert property (
      $rose(resetn_in) |-> (mux_cur_w == SRC_SLOW) && slow_internal_osc_en_out && !mux_busy_w)
      else $error("Boot did not start on the slow internal oscillator.");
   osc_enable_write_a: assert property (
      (wr_commit_w && wr_id_w == RID_CSC && r_r.w_strb[0])
      |=> fast_internal_osc_en_out == $past(r_r.w_data[`CSC_FAST_BIT])
          && main_crystal_osc_en_out == $past(r_r.w_data[`CSC_MAIN_XTAL_BIT]))
      else $error("Oscillator enables did not follow the register write.");
   select_write_a: assert property (
      (wr_commit_w && wr_id_w == RID_SCS && r_r.w_strb[0])
      |=> r_r.scs[`SCS_SEL_MSB:0] == $past(r_r.w_data[`SCS_SEL_MSB:0]) && s_axi_bvalid_out)
      else $error("Source select did not follow the register write.");
   core_clock_pd_a: assert property (
      (mode_in == MODE_PD && !main_lvl_w) ##1 (mode_in == MODE_PD) |=> !free_running_core_clock_out)
      else $error("Core clock kept running in power-down.");
   cpu_clock_sleep_a: assert property (
      (mode_in == MODE_SLEEP && !main_lvl_w) ##1 (mode_in == MODE_SLEEP) |=> !cpu_bus_clock_out)
      else $error("CPU clock kept running in sleep.");
   cpu_clock_run_a: assert property (
      (mode_in == MODE_RUN && !main_lvl_w) ##1 (mode_in == MODE_RUN && main_lvl_w) |=> cpu_bus_clock_out)
      else $error("CPU clock missed a main clock pulse in run mode.");
   periph_gate_off_a: assert property (
      (!r_r.pce_one[0] && !pm_lvl_w) ##1 (!r_r.pce_one[0]) |=> !periph_clock_out[0])
      else $error("Disabled peripheral clock still toggles.");
   access_follows_a: assert property (
      (wr_commit_w && wr_id_w == RID_PCE1 && r_r.w_strb == 4'hF)
      |=> periph_access_en_out[31:0] == $past(r_r.w_data))
      else $error("Peripheral access enables do not match the clock enables.");
   checksum_clock_pd_a: assert property (
      (mode_in == MODE_PD && !main_lvl_w) ##1 (mode_in == MODE_PD) |=> !checksum_unit_clock_out)
      else $error("Checksum unit clock kept running in power-down.");
   flash_wait_write_a: assert property (
      (wr_commit_w && wr_id_w == RID_FWAIT && r_r.w_strb[0])
      |=> flash_wait_states_out == $past(r_r.w_data[`FWAIT_MSB:0]))
      else $error("Flash wait field did not follow the register write.");

   fast_selected_c: cover property (mux_busy_w ##[1:1000] (!mux_busy_w && mux_cur_w == SRC_FAST));
   sleep_entered_c: cover property ((mode_in == MODE_SLEEP) [*3] ##1 main_lvl_w);
   write_answered_c: cover property (s_axi_bvalid_out && s_axi_bready_in);
   periph_toggle_c: cover property ($rose(periph_clock_out[0]));

endmodule : system_clock_control

// >>> verif/system_clock_control_tb.sv
// Self-checking bench for the clock control block driven over its register bus.
`timescale 1ns/1ps
`include "clk_ctrl_consts.svh"

module system_clock_control_tb;
   import clk_ctrl_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic pm_prev;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, fws, r;
   logic [31:0] rdata, d;
   logic [3:0] osc_en;
   logic [63:0] pclk, paccess;
   wire [5:0] obs;
   logic [6:0] cnt = 7'h00;
   op_mode_t mode = MODE_RUN;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int t, n;
   logic [11:0] ra [5] = '{`PCE_ONE_OFS, `PCE_TWO_OFS, `CSC_OFS, `SCS_OFS, `FWAIT_OFS};
   logic [31:0] rv [5] = '{`PCE_ONE_RST, `PCE_TWO_RST, `CSC_RST, `SCS_RST, `FWAIT_RST};
   logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
   logic [1:0] waits [4] = '{2'h0, 2'h2, 2'h1, 2'h3};

   always #4 clk_in = ~clk_in;
   // Oscillators are slow square waves of distinct periods, at least four cycles per level.
   always @(posedge clk_in) cnt <= cnt + 7'h01;
   assign obs[5] = pclk[0];

   system_clock_control dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      // A crystal runs only once enabled; its pins count as already set to their crystal functions.
      .slow_internal_osc_in(cnt[5]), .sub_crystal_osc_in(cnt[4] & osc_en[1]),
      .fast_internal_osc_in(cnt[2]), .main_crystal_osc_in(cnt[3] & osc_en[3]), .mode_in(mode),
      .slow_internal_osc_en_out(osc_en[0]), .sub_crystal_osc_en_out(osc_en[1]),
      .fast_internal_osc_en_out(osc_en[2]), .main_crystal_osc_en_out(osc_en[3]),
      .main_clock_out(obs[0]), .free_running_core_clock_out(obs[1]), .cpu_bus_clock_out(obs[2]),
      .periph_master_clock_out(obs[3]), .checksum_unit_clock_out(obs[4]), .periph_clock_out(pclk),
      .periph_access_en_out(paccess), .flash_wait_states_out(fws));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test

   // Address and data are offered together and each is released once taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge clk_in);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge clk_in); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic toggles(input int i, input int len);
      logic p;
      t = 0;
      p = obs[i];
      repeat (len)
      begin
         @(posedge clk_in);
         if (obs[i] !== p)
            t++;
         p = obs[i];
      end
   endtask : toggles

   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_count++;
         finish_test();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      check(osc_en, 4'b0001);
      check(paccess, {32'h00000101, 32'h0000000F});
      for (int i = 0; i < 5; i++)
      begin
         rd(ra[i]);
         check({r, d}, {`RESP_OKAY, rv[i]});
      end
      rd(`CSTAT_OFS);
      check(d[1:0], SRC_SLOW);
      toggles(0, 160);
      check(t > 0, 1'b1);
      wr(`CSC_OFS, 32'hFFFFFFFF);
      check(osc_en, 4'b1111);
      // Crystal settling time is scaled down to keep the run short.
      repeat (64) @(posedge clk_in);
      rd(`CSC_OFS);
      check(d, 32'h00000033);
      for (int i = 0; i < 4; i++)
      begin
         wr(`FWAIT_OFS, {30'h0, waits[i]});
         check(fws, waits[i]);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(`SCS_OFS, {30'h0, codes[i]});
         n = 0;
         do
         begin
            rd(`CSTAT_OFS);
            n++;
         end
         while ((d[2] !== 1'b0 || d[1:0] !== codes[i]) && n < 200);
         check(d[2:0], {1'b0, codes[i]});
      end
      for (int j = 0; j < 4; j++)
      begin
         mode <= op_mode_t'(j);
         repeat (20) @(posedge clk_in);
         for (int i = 0; i < 5; i++)
         begin
            toggles(i, 40);
            check(t > 0, (i == 2) ? (j == 0 || j == 3) : (i == 0 || j != 2));
         end
      end
      mode <= MODE_RUN;
      toggles(5, 40);
      check(t > 0, 1'b1);
      wr(`PCE_ONE_OFS, 32'h00000000);
      check(paccess[31:0], 32'h00000000);
      repeat (10) @(posedge clk_in);
      toggles(5, 40);
      check(t, 0);
      wr(`PCE_TWO_OFS, 32'hFFFFFFFF);
      check(paccess[63:32], 32'hFFFFFFFF);
      repeat (10) @(posedge clk_in);
      for (int k = 0; k < 8; k++)
      begin
         pm_prev = obs[3];
         @(posedge clk_in);
         check(pclk, {{32{pm_prev}}, 32'h00000000});
      end
      wstrb <= 4'h2;
      wr(`PCE_TWO_OFS, 32'h00000000);
      wstrb <= 4'hF;
      check(paccess[63:32], 32'hFFFF00FF);
      wr(`CSTAT_OFS, 32'hFFFFFFFF);
      check(r, `RESP_OKAY);
      wr(12'h100, 32'h12345678);
      check(r, `RESP_SLVERR);
      rd(12'h100);
      check({r, d}, {`RESP_SLVERR, 32'h00000000});
      finish_test();
   end
endmodule : system_clock_control_tb
